// ==== hdl/fcr_unit.sv ====
`timescale 1ns/10ps
// Summary of operation
// - every hardware fault enters as an input
// - each fault has own reaction setting
// - reactions: none, interrupt, reset, nmi
// - collection runs without processor help
// - on fault enter safe state, report
// - error-outs tristated while held in reset
// - single mode reports on primary only
// - enable, reaction, timeout regs writable only in config
// - error-out reporting cannot be disabled
// - pad disable bit tristates system outputs in safe state
// - software clears status, back to normal
module fcr_unit
    import fcr_pkg::*;
#(
    parameter int NF = fcr_pkg::NUM_FAULTS
) (
    input  wire logic          clk,          // 20 MHz system clock
    input  wire logic          rst_n,        // async reset, low
    input  wire logic [NF-1:0] faultIn,      // raw fault lines
    input  wire logic          psel,         // apb select
    input  wire logic          penable,      // apb access phase
    input  wire logic          pwrite,       // apb direction
    input  wire logic [7:0]    paddr,        // apb byte address
    input  wire logic [31:0]   pwdata,       // apb write data
    output logic               pready,       // apb ready
    output logic               pslverr,      // apb error
    output logic [31:0]        prdata,       // apb read data
    output logic               errOutPri,    // primary error-out
    output logic               errOutPriOe,  // primary drive enable
    output logic               errOutSec,    // secondary error-out
    output logic               errOutSecOe,  // secondary drive enable
    output logic               irq,          // level interrupt
    output logic               nmi,          // non-maskable request
    output logic               funcReset,    // functional reset req
    output logic               padDisable    // tristate system pads
);
    import fcr_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    fcr_state_t       state;
    logic [NF-1:0]    faultSync;
    logic [NF-1:0]    faultEn;
    logic [2*NF-1:0]  reactSel;
    logic [NF-1:0]    toEn;
    logic [NF-1:0]    faultStat;
    logic [NUM_EV-1:0] evStat;
    logic [NUM_EV-1:0] evEn;
    logic             singleMode;
    logic             pdoBit;
    logic [31:0]      toLimit;
    logic [31:0]      toCount;
    logic             wrAcc;
    logic             rdAcc;
    logic             addrOk;
    logic [NF-1:0]    newFault;
    logic [NF-1:0]    clrFault;
    logic [NF-1:0]    wantIrq;
    logic [NF-1:0]    wantNmi;
    logic [NF-1:0]    wantRst;
    logic [NF-1:0]    direct;
    logic             toExpire;
    logic [NUM_EV-1:0] evSet;
    logic [NUM_EV-1:0] evClr;
    logic [31:0]      next_rdata;

    // ------------------------------------------------------------
    // fault input synchroniser
    // ------------------------------------------------------------
    // every fault enters
    fcr_sync #(
        .W (NF)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (faultIn),
        .q     (faultSync)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // zero wait states: ready rises in every access phase
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign addrOk = (paddr[1:0] == 2'b00) && (paddr <= OFS_TIMEOUT);

    // per-fault decode of reaction field
    always_comb begin
        for (int i = 0; i < NF; i++) begin
            wantIrq[i] = reactSel[2*i +: 2] == RE_IRQ;
            wantNmi[i] = reactSel[2*i +: 2] == RE_NMI;
            wantRst[i] = reactSel[2*i +: 2] == RE_RESET;
            // no-timeout faults skip the alarm stage
            direct[i]  = !toEn[i];
        end
    end

    assign newFault = faultSync & faultEn & ~faultStat;
    assign clrFault = (wrAcc && paddr == OFS_FCLEAR) ?
                      pwdata[NF-1:0] : '0;
    assign toExpire = (state == FCR_ALARM) && (toCount >= toLimit);

    // ------------------------------------------------------------
    // fault status
    // ------------------------------------------------------------
    // sticky until cleared, set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultStat <= '0;
        end else begin
            faultStat <= (faultStat & ~clrFault) | (faultSync & faultEn);
        end
    end

    // ------------------------------------------------------------
    // unit state machine
    // ------------------------------------------------------------
    // runs on its own, no processor needed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FCR_CONFIG;
        end else begin
            case (state)
                FCR_CONFIG: begin
                    if (wrAcc && paddr == OFS_CTRL &&
                        pwdata[CTRL_OP_LSB +: 2] == OP_NORMAL) begin
                        state <= FCR_NORMAL;
                    end
                end
                FCR_NORMAL: begin
                    if (|(newFault & direct)) begin
                        state <= FCR_FAULT;
                    end else if (|newFault) begin
                        state <= FCR_ALARM;
                    end else if (wrAcc && paddr == OFS_CTRL &&
                        pwdata[CTRL_OP_LSB +: 2] == OP_CONFIG) begin
                        state <= FCR_CONFIG;
                    end
                end
                FCR_ALARM: begin
                    if (toExpire || |(newFault & direct)) begin
                        state <= FCR_FAULT;
                    end else if (faultStat == '0) begin
                        state <= FCR_NORMAL;
                    end
                end
                FCR_FAULT: begin
                    if (faultStat == '0 && newFault == '0) begin
                        state <= FCR_NORMAL;
                    end
                end
                default: state <= FCR_CONFIG;
            endcase
        end
    end

    // alarm timeout counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toCount <= '0;
        end else if (state == FCR_ALARM) begin
            toCount <= toCount + 32'h0000_0001;
        end else begin
            toCount <= '0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // writes honoured only in config state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultEn  <= NF'(RST_FENABLE);
            reactSel <= '0;
            toEn     <= '0;
            toLimit  <= RST_TIMEOUT;
        end else if (wrAcc && state == FCR_CONFIG) begin
            case (paddr)
                OFS_FENABLE: faultEn  <= pwdata[NF-1:0];
                OFS_FREACT:  reactSel <= pwdata[2*NF-1:0];
                OFS_FTOE:    toEn     <= pwdata[NF-1:0];
                OFS_TIMEOUT: toLimit  <= pwdata;
                default:     faultEn  <= faultEn;
            endcase
        end
    end

    // free control bits, usable in any state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            singleMode <= 1'b0;
            pdoBit     <= 1'b0;
            evEn       <= '0;
        end else if (wrAcc) begin
            if (paddr == OFS_CTRL) begin
                singleMode <= pwdata[CTRL_SINGLE];
            end
            if (paddr == OFS_SAFECTL) begin
                pdoBit <= pwdata[SAFECTL_PDO];
            end
            if (paddr == OFS_IRQEN) begin
                evEn <= pwdata[NUM_EV-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    assign evSet[EV_FAULT]  = |(newFault & wantIrq);
    assign evSet[EV_ALARM]  = toExpire;
    assign evSet[EV_FAULTS] = ((state == FCR_NORMAL || state == FCR_ALARM) &&
                               |(newFault & direct)) || toExpire;
    assign evClr = (wrAcc && paddr == OFS_IRQCLR) ?
                   pwdata[NUM_EV-1:0] : '0;

    // sticky, a new event beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evStat <= '0;
        end else begin
            evStat <= (evStat & ~evClr) | evSet;
        end
    end

    // ------------------------------------------------------------
    // reactions
    // ------------------------------------------------------------
    // graded reactions per fault
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq       <= 1'b0;
            nmi       <= 1'b0;
            funcReset <= 1'b0;
        end else begin
            irq       <= |((evStat | evSet) & evEn);
            nmi       <= |(faultStat & wantNmi);
            funcReset <= |(newFault & wantRst & direct) || // timed: at expiry
                         (toExpire && |(faultStat & wantRst));
        end
    end

    // error outs: primary low and secondary high report failure
    // tristated while in reset, enables clear to 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errOutPri   <= 1'b0;
            errOutPriOe <= 1'b0;
            errOutSec   <= 1'b0;
            errOutSecOe <= 1'b0;
        end else begin
            errOutPri   <= (state != FCR_FAULT);
            errOutPriOe <= 1'b1;
            errOutSec   <= (state == FCR_FAULT);
            errOutSecOe <= !singleMode;
        end
    end

    // pads tristated in safe state when enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            padDisable <= 1'b0;
        end else begin
            padDisable <= pdoBit && (state == FCR_FAULT);
        end
    end

    // ------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = BAD_READ;
        case (paddr)
            OFS_CTRL:    next_rdata[CTRL_SINGLE] = singleMode;
            OFS_STATE:   next_rdata[1:0] = state;
            OFS_FENABLE: next_rdata[NF-1:0] = faultEn;
            OFS_FREACT:  next_rdata[2*NF-1:0] = reactSel;
            OFS_FTOE:    next_rdata[NF-1:0] = toEn;
            OFS_FSTATUS: next_rdata[NF-1:0] = faultStat;
            OFS_IRQSTAT: next_rdata[NUM_EV-1:0] = evStat;
            OFS_IRQEN:   next_rdata[NUM_EV-1:0] = evEn;
            OFS_SAFECTL: next_rdata[SAFECTL_PDO] = pdoBit;
            OFS_TIMEOUT: next_rdata = toLimit;
            default:     next_rdata = BAD_READ;
        endcase
    end

    // registered answer, ready in the first access cycle, no wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrOk;
            prdata  <= (psel && !penable && !pwrite) ? next_rdata : '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    cfg_lock_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state != FCR_CONFIG) |=> $stable(faultEn) || $past(state) ==
            FCR_CONFIG)
        else $error("fault enable changed outside config");

    sticky_stat_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (faultStat[0] && !clrFault[0]) |=> faultStat[0])
        else $error("fault status dropped without clear");

    fault_latch_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (faultSync[0] && faultEn[0]) |=> faultStat[0])
        else $error("enabled fault not latched");

    safe_state_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state == FCR_NORMAL && |(newFault & direct)) |=>
            state == FCR_FAULT ##1 !errOutPri)
        else $error("direct fault missed safe state");

    eout_drive_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state == FCR_FAULT) |=> errOutPriOe && !errOutPri)
        else $error("failure not reported on primary");

    single_mode_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        singleMode |=> !errOutSecOe)
        else $error("secondary driven in single mode");

    pad_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pdoBit && state == FCR_FAULT) |=> padDisable)
        else $error("pads not disabled in safe state");

    react_irq_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (evSet[EV_FAULT] && evEn[EV_FAULT]) |=> irq)
        else $error("interrupt reaction missing");

    return_norm_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (state == FCR_FAULT && faultStat == '0 && newFault == '0) |=>
            state == FCR_NORMAL)
        else $error("no return to normal after clear");
endmodule // fcr_unit

// ==== hdl/fcr_pkg.sv ====
package fcr_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_FAULTS = 8;
    localparam int ADDR_W     = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00; // op / single mode
    localparam logic [7:0] OFS_STATE    = 8'h04; // unit state, read only
    localparam logic [7:0] OFS_FENABLE  = 8'h08; // fault enable config
    localparam logic [7:0] OFS_FREACT   = 8'h0C; // reaction select
    localparam logic [7:0] OFS_FTOE     = 8'h10; // timeout enable
    localparam logic [7:0] OFS_FSTATUS  = 8'h14; // latched faults
    localparam logic [7:0] OFS_FCLEAR   = 8'h18; // write 1 to clear
    localparam logic [7:0] OFS_IRQSTAT  = 8'h1C; // sticky events
    localparam logic [7:0] OFS_IRQEN    = 8'h20; // event enable
    localparam logic [7:0] OFS_IRQCLR   = 8'h24; // write 1 to clear
    localparam logic [7:0] OFS_SAFECTL  = 8'h28; // pad disable bit
    localparam logic [7:0] OFS_TIMEOUT  = 8'h2C; // timeout count

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int CTRL_OP_LSB   = 0;  // op field [1:0]
    localparam int CTRL_SINGLE   = 4;  // single error-out mode
    localparam int SAFECTL_PDO   = 0;
    localparam logic [1:0] OP_NONE   = 2'h0;
    localparam logic [1:0] OP_CONFIG = 2'h1;
    localparam logic [1:0] OP_NORMAL = 2'h2;
    localparam int EV_FAULT  = 0;   // event bit: interrupt-reaction fault latched
    localparam int EV_ALARM  = 1;   // event bit: timeout expired
    localparam int EV_FAULTS = 2;   // event bit: safe state entered
    localparam int NUM_EV    = 3;

    // reaction codes, two bits a fault
    localparam logic [1:0] RE_NONE  = 2'h0;
    localparam logic [1:0] RE_IRQ   = 2'h1;
    localparam logic [1:0] RE_RESET = 2'h2;
    localparam logic [1:0] RE_NMI   = 2'h3;

    localparam logic [31:0] RST_FENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_TIMEOUT = 32'h0000_0100;
    localparam logic [31:0] BAD_READ    = 32'h0000_0000;

    // ------------------------------------------------------------
    // unit states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FCR_NORMAL = 2'b00,
        FCR_CONFIG = 2'b01,
        FCR_ALARM  = 2'b10,
        FCR_FAULT  = 2'b11
    } fcr_state_t;
endpackage

// ==== hdl/fcr_sync.sv ====
`timescale 1ns/10ps
module fcr_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,   // system clock
    input  wire logic         rst_n, // async reset
    input  wire logic [W-1:0] d,     // asynchronous inputs
    output logic      [W-1:0] q      // synchronised outputs
);
    logic [W-1:0] stage1;

    // two-flop synchroniser, stage1 read only by q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // fcr_sync

// ==== testbench/fcr_ext_monitor.sv ====
`timescale 1ns/10ps
module fcr_ext_monitor (
    input  wire logic clk,        // system clock
    input  wire logic rst_n,      // monitor release, low
    input  wire logic priLine,    // primary error-out wire
    input  wire logic secLine,    // secondary error-out wire
    input  wire logic singleMode, // only primary in use
    output logic      safeHold    // system held safe
);
    logic failSeen;

    // a floating line is no failure: reset is judged elsewhere
    assign failSeen = (priLine === 1'b0) ||
                      (!singleMode && secLine === 1'b1);

    // ------------------------------------------------------------
    // failure watch
    // ------------------------------------------------------------
    // latch and hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            safeHold <= 1'b0;
        end else if (failSeen) begin
            safeHold <= 1'b1;
        end
    end
endmodule // fcr_ext_monitor

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import fcr_pkg::*;
    logic                  clk, rst_n, monRst_n, singleMode;
    logic [NUM_FAULTS-1:0] faultIn;
    logic                  psel, penable, pwrite, pready, pslverr;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata;
    logic                  errOutPri, errOutPriOe, errOutSec, errOutSecOe;
    logic                  irq, nmi, funcReset, padDisable, safeHold;
    wire                   priLine, secLine;
    int                    nMismatch, samplesChecked, rstCount;

    // pins float while their enable is low
    assign priLine = errOutPriOe ? errOutPri : 1'bz;
    assign secLine = errOutSecOe ? errOutSec : 1'bz;

    fcr_unit #(.NF(NUM_FAULTS)) i_fcr_unit (
        .clk(clk), .rst_n(rst_n), .faultIn(faultIn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .errOutPri(errOutPri),
        .errOutPriOe(errOutPriOe), .errOutSec(errOutSec),
        .errOutSecOe(errOutSecOe), .irq(irq), .nmi(nmi),
        .funcReset(funcReset), .padDisable(padDisable));

    fcr_ext_monitor i_fcr_ext_monitor (
        .clk(clk), .rst_n(monRst_n), .priLine(priLine),
        .secLine(secLine), .singleMode(singleMode),
        .safeHold(safeHold));

    // ------------------------------------------------------------
    // clock and pulse counting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // reset requests are one-cycle pulses, so count them as they pass
    always @(posedge clk) begin
        if (funcReset === 1'b1) rstCount <= rstCount + 1;
    end

    // ------------------------------------------------------------
    // compare, bus and fault tasks
    // ------------------------------------------------------------
    task automatic chkBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high, then released
    task automatic apbXfer(input logic [7:0] a, input logic wr,
                           input logic [31:0] wd, output logic [31:0] rd,
                           output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) nMismatch++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apbXfer(a, 1'b1, d, rd, err);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apbXfer(a, 1'b0, 32'h0, rd, err);
        chkWord(rd & mask, exp);
        chkBit(err, expErr);
    endtask

    // line held three cycles so the two-flop sync cannot miss it
    task automatic inject(input int idx);
        @(posedge clk);
        faultIn[idx] <= 1'b1;
        repeat (3) @(posedge clk);
        faultIn <= '0;
        repeat (5) @(posedge clk);
    endtask

    task automatic clearAll();
        wr(OFS_FCLEAR, 32'hFF);
        wr(OFS_IRQCLR, 32'h7);
        repeat (3) @(posedge clk);
        monRst_n <= 1'b0;
        @(posedge clk);
        monRst_n <= 1'b1;
    endtask

    task automatic conclude();
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        faultIn = '0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; rst_n = 1'b0; monRst_n = 1'b0;
        singleMode = 1'b0; nMismatch = 0; samplesChecked = 0;
        rstCount = 0;
        repeat (8) @(posedge clk);
        chkBit(errOutPriOe, 1'b0);
        chkBit(errOutSecOe, 1'b0);
        rst_n <= 1'b1;
        monRst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chkBit(errOutPri, 1'b1);
        chkBit(errOutSecOe, 1'b1);
        rdChk(OFS_STATE, 32'(FCR_CONFIG), 32'h3, 1'b0);
        // f0 irq, f1 reset, f2 nmi, f3 none; f4 and up disabled
        wr(OFS_FENABLE, 32'h0F);
        wr(OFS_FREACT, 32'h39);
        wr(OFS_FTOE, 32'h0);
        wr(OFS_IRQEN, 32'h1);
        wr(OFS_SAFECTL, 32'h1);
        rdChk(OFS_FREACT, 32'h39, 32'hFF, 1'b0);
        rdChk(8'h30, 32'h0, 32'hFFFF_FFFF, 1'b1);
        wr(OFS_CTRL, 32'h2);
        rdChk(OFS_STATE, 32'(FCR_NORMAL), 32'h3, 1'b0);
        wr(OFS_FENABLE, 32'hFF);
        wr(OFS_FREACT, 32'h0);
        rdChk(OFS_FENABLE, 32'h0F, 32'hFF, 1'b0);
        rdChk(OFS_FREACT, 32'h39, 32'hFF, 1'b0);
        inject(0);
        chkBit(errOutPri, 1'b0);
        chkBit(errOutSec, 1'b1);
        chkBit(padDisable, 1'b1);
        chkBit(irq, 1'b1);
        chkBit(safeHold, 1'b1);
        rdChk(OFS_STATE, 32'(FCR_FAULT), 32'h3, 1'b0);
        rdChk(OFS_FSTATUS, 32'h1, 32'hFF, 1'b0);
        rdChk(OFS_IRQSTAT, 32'h5, 32'h7, 1'b0);
        clearAll();
        rdChk(OFS_STATE, 32'(FCR_NORMAL), 32'h3, 1'b0);
        chkBit(errOutPri, 1'b1);
        chkBit(irq, 1'b0);
        chkBit(padDisable, 1'b0);
        wr(OFS_IRQEN, 32'h0);
        inject(0);
        chkBit(irq, 1'b0);
        rdChk(OFS_IRQSTAT, 32'h1, 32'h1, 1'b0);
        clearAll();
        inject(1);
        chkWord(32'(rstCount), 32'h1);
        chkBit(nmi, 1'b0);
        clearAll();
        inject(2);
        chkBit(nmi, 1'b1);
        clearAll();
        chkBit(nmi, 1'b0);
        inject(3);
        chkBit(errOutPri, 1'b0);
        clearAll();
        inject(4);
        chkBit(errOutPri, 1'b1);
        rdChk(OFS_FSTATUS, 32'h0, 32'hFF, 1'b0);
        wr(OFS_CTRL, 32'h11);
        // f3 gets an alarm stage of seventeen cycles (limit 16) before the safe state
        wr(OFS_FTOE, 32'h08);
        wr(OFS_TIMEOUT, 32'h10);
        rdChk(OFS_FTOE, 32'h08, 32'hFF, 1'b0);
        rdChk(OFS_TIMEOUT, 32'h10, 32'hFFFF_FFFF, 1'b0);
        wr(OFS_CTRL, 32'h12);
        singleMode <= 1'b1;
        @(posedge clk);
        chkBit(errOutSecOe, 1'b0);
        inject(0);
        chkBit(errOutPri, 1'b0);
        chkBit(errOutPriOe, 1'b1);
        chkBit(errOutSecOe, 1'b0);
        chkBit(safeHold, 1'b1);
        clearAll();
        // timed fault: alarm first, safe state once the count runs out
        inject(3);
        rdChk(OFS_STATE, 32'(FCR_ALARM), 32'h3, 1'b0);
        chkBit(safeHold, 1'b0);
        repeat (16) @(posedge clk);
        rdChk(OFS_STATE, 32'(FCR_FAULT), 32'h3, 1'b0);
        rdChk(OFS_IRQSTAT, 32'h6, 32'h7, 1'b0);
        chkBit(errOutPri, 1'b0);
        chkBit(safeHold, 1'b1);
        clearAll();
        inject(3);
        rst_n <= 1'b0;
        @(posedge clk);
        chkBit(errOutPriOe, 1'b0);
        chkBit(errOutSecOe, 1'b0);
        conclude();
    end
endmodule // testbench
